// File: src/sxa_pkg.sv
// Behaviour
// - Literal minus accumulator lands in accumulator
// - Subtract sets carry, half-carry on no borrow
// - File minus accumulator goes where destination says
// - File exclusive OR touches only zero flag
// - Nibble exchange to destination, flags untouched
// - Literal exclusive OR into accumulator, zero only
package sxa_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int NIB_W = 4;
    localparam int AV_ADDR_W = 4;
    localparam int AV_DATA_W = 32;
    localparam int OPCNT_W = 16;

    // Byte addresses on the Avalon slave
    localparam logic [AV_ADDR_W-1:0] ACC_OFS = 4'h0;
    localparam logic [AV_ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [AV_ADDR_W-1:0] OPCNT_OFS = 4'h8;

    // Status register field positions
    localparam int CARRY_BIT = 0;
    localparam int HALF_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;

    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [OPCNT_W-1:0] OPCNT_RST = 16'h0000;
    localparam logic [AV_DATA_W-1:0] RDATA_RST = 32'h00000000;

    typedef enum logic [2:0] {
        literal_minus_acc_op = 3'h0,
        file_minus_acc_op = 3'h1,
        acc_file_exclusive_or_op = 3'h2,
        nibble_exchange_op = 3'h3,
        acc_literal_exclusive_or_op = 3'h4
    } sxa_op_type;

    // Gray-coded bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ANSWER = 2'h1
    } sxa_bus_type;

    typedef struct packed {
        logic valid;
        sxa_op_type code;
        logic [FADDR_W-1:0] faddr;
        logic dest_file;
        logic [DATA_W-1:0] literal;
    } sxa_instr_type;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sxa_fwrite_type;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic carry;
        logic half_carry_flag;
        logic zero;
        sxa_fwrite_type fwr;
        logic done;
        logic [OPCNT_W-1:0] opcnt;
        sxa_bus_type bus;
        logic waitreq;
        logic [AV_DATA_W-1:0] rdata;
    } sxa_state_type;
endpackage : sxa_pkg

// File: src/sxa_alu.sv
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module sxa_alu #(
    parameter int COUNT_W = 16
) (
    input wire logic CLOCK_IN,
    input wire logic RESETN_IN,
    input wire sxa_pkg::sxa_instr_type INSTR_IN,
    input wire logic [sxa_pkg::DATA_W-1:0] FILE_DATA_IN,
    output sxa_pkg::sxa_fwrite_type FILE_WRITE_OUT,
    output logic [sxa_pkg::DATA_W-1:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic HALF_CARRY_OUT,
    output logic ZERO_OUT,
    output logic DONE_OUT,
    input wire logic [sxa_pkg::AV_ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [sxa_pkg::AV_DATA_W-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [sxa_pkg::AV_DATA_W-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT
);
    import sxa_pkg::*;

    // Counter width is fixed by OPCNT_W in the package
    if (COUNT_W != OPCNT_W) begin : g_bad_width
        $error("COUNT_W must equal OPCNT_W");
    end

    sxa_state_type s_q;
    sxa_state_type s_d;
    logic bus_go;
    logic bus_wr_go;
    logic [DATA_W-1:0] res;

    // Subtract a minus b; top bits are carry and half-carry, set when no borrow
    function automatic logic [DATA_W+1:0] sub8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        logic [DATA_W:0] full;
        logic [NIB_W:0] low;
        full = {1'b0, a} - {1'b0, b};
        low = {1'b0, a[NIB_W-1:0]} - {1'b0, b[NIB_W-1:0]};
        sub8 = {~full[DATA_W], ~low[NIB_W], full[DATA_W-1:0]};
    endfunction : sub8

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    // Accepted bus access in this cycle
    assign bus_go = (AVS_READ_IN || AVS_WRITE_IN) && (s_q.bus == BUS_ANSWER);
    assign bus_wr_go = bus_go && AVS_WRITE_IN;

    // Next state: bus write first, so an operation in the same cycle wins
    always_comb begin
        logic [DATA_W+1:0] sub;
        sub = '0;
        res = '0;
        s_d = s_q;
        s_d.fwr.we = 1'b0;
        s_d.done = 1'b0;
        if (bus_wr_go && AVS_BYTEENABLE_IN[0]) begin
            if (AVS_ADDRESS_IN == ACC_OFS) begin
                s_d.acc = AVS_WRITEDATA_IN[DATA_W-1:0];
            end else if (AVS_ADDRESS_IN == STATUS_OFS) begin
                s_d.carry = AVS_WRITEDATA_IN[CARRY_BIT];
                s_d.half_carry_flag = AVS_WRITEDATA_IN[HALF_CARRY_BIT];
                s_d.zero = AVS_WRITEDATA_IN[ZERO_BIT];
            end
        end
        if (INSTR_IN.valid) begin
            s_d.done = 1'b1;
            s_d.opcnt = s_q.opcnt + 16'h0001;
            s_d.fwr.addr = INSTR_IN.faddr;
            case (INSTR_IN.code)
                literal_minus_acc_op: begin
                    sub = sub8(INSTR_IN.literal, s_q.acc);
                    res = sub[DATA_W-1:0];
                    s_d.acc = res;
                    s_d.carry = sub[DATA_W+1];
                    s_d.half_carry_flag = sub[DATA_W];
                    s_d.zero = is_zero(res);
                end
                file_minus_acc_op: begin
                    sub = sub8(FILE_DATA_IN, s_q.acc);
                    res = sub[DATA_W-1:0];
                    s_d.carry = sub[DATA_W+1];
                    s_d.half_carry_flag = sub[DATA_W];
                    s_d.zero = is_zero(res);
                end
                acc_file_exclusive_or_op: begin
                    res = s_q.acc ^ FILE_DATA_IN;
                    s_d.zero = is_zero(res);
                end
                nibble_exchange_op: begin
                    res = {FILE_DATA_IN[NIB_W-1:0], FILE_DATA_IN[DATA_W-1:NIB_W]};
                end
                acc_literal_exclusive_or_op: begin
                    res = s_q.acc ^ INSTR_IN.literal;
                    s_d.acc = res;
                    s_d.zero = is_zero(res);
                end
                default: begin
                    s_d.done = 1'b0;
                end
            endcase
            // File-addressed results obey the destination bit
            if (INSTR_IN.code inside {file_minus_acc_op, acc_file_exclusive_or_op, nibble_exchange_op}) begin
                if (INSTR_IN.dest_file) begin
                    s_d.fwr.we = 1'b1;
                    s_d.fwr.data = res;
                end else begin
                    s_d.acc = res;
                end
            end
        end
        // Bus answers one cycle after it sees a request; read data already includes any operation result from that same cycle
        case (s_q.bus)
            BUS_IDLE: begin
                s_d.waitreq = 1'b1;
                if (AVS_READ_IN || AVS_WRITE_IN) begin
                    s_d.bus = BUS_ANSWER;
                    s_d.waitreq = 1'b0;
                    s_d.rdata = RDATA_RST;
                    if (AVS_ADDRESS_IN == ACC_OFS) begin
                        s_d.rdata[DATA_W-1:0] = s_d.acc;
                    end else if (AVS_ADDRESS_IN == STATUS_OFS) begin
                        s_d.rdata[CARRY_BIT] = s_d.carry;
                        s_d.rdata[HALF_CARRY_BIT] = s_d.half_carry_flag;
                        s_d.rdata[ZERO_BIT] = s_d.zero;
                    end else if (AVS_ADDRESS_IN == OPCNT_OFS) begin
                        s_d.rdata[OPCNT_W-1:0] = s_d.opcnt;
                    end
                end
            end
            BUS_ANSWER: begin
                s_d.bus = BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
            default: begin
                s_d.bus = BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s_q <= '0;
            s_q.acc <= ACC_RST;
            s_q.opcnt <= OPCNT_RST;
            s_q.bus <= BUS_IDLE;
            s_q.waitreq <= 1'b1;
            s_q.rdata <= RDATA_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign FILE_WRITE_OUT = s_q.fwr;
    assign ACC_OUT = s_q.acc;
    assign CARRY_OUT = s_q.carry;
    assign HALF_CARRY_OUT = s_q.half_carry_flag;
    assign ZERO_OUT = s_q.zero;
    assign DONE_OUT = s_q.done;
    assign AVS_READDATA_OUT = s_q.rdata;
    assign AVS_WAITREQUEST_OUT = s_q.waitreq;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_issue(sxa_op_type c);
        INSTR_IN.valid && INSTR_IN.code == c;
    endsequence
    // Destination test fused to the issue cycle
    sequence s_issue_file(sxa_op_type c, logic d);
        s_issue(c) ##0 INSTR_IN.dest_file == d;
    endsequence

    property p_lit_minus_acc;
        s_issue(literal_minus_acc_op) |=> ACC_OUT == 8'($past(INSTR_IN.literal) - $past(ACC_OUT)) && !FILE_WRITE_OUT.we;
    endproperty
    a_lit_minus_acc: assert property (p_lit_minus_acc) else $error("literal minus acc result wrong");

    property p_sub_flags;
        s_issue(literal_minus_acc_op) ##0 !bus_wr_go |=> CARRY_OUT == ($past(ACC_OUT) <= $past(INSTR_IN.literal))
            && HALF_CARRY_OUT == ($past(ACC_OUT[3:0]) <= $past(INSTR_IN.literal[3:0]));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract carry flags wrong");

    property p_file_minus_acc;
        s_issue_file(file_minus_acc_op, 1'b1) ##0 !bus_wr_go |=> FILE_WRITE_OUT.we
            && FILE_WRITE_OUT.data == 8'($past(FILE_DATA_IN) - $past(ACC_OUT)) && $stable(ACC_OUT)
            && CARRY_OUT == ($past(ACC_OUT) <= $past(FILE_DATA_IN)) ##1 !FILE_WRITE_OUT.we || DONE_OUT;
    endproperty
    a_file_minus_acc: assert property (p_file_minus_acc) else $error("file minus acc wrong");

    property p_xor_file;
        s_issue(acc_file_exclusive_or_op) ##0 !bus_wr_go |=> $stable(CARRY_OUT) && $stable(HALF_CARRY_OUT)
            && (FILE_WRITE_OUT.we ? FILE_WRITE_OUT.data : ACC_OUT) == ($past(ACC_OUT) ^ $past(FILE_DATA_IN));
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("file xor wrong");

    property p_swap;
        s_issue_file(nibble_exchange_op, 1'b0) ##0 !bus_wr_go |=> !FILE_WRITE_OUT.we && $stable(ZERO_OUT)
            && $stable(CARRY_OUT) && ACC_OUT == {$past(FILE_DATA_IN[3:0]), $past(FILE_DATA_IN[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");

    property p_xor_lit;
        s_issue(acc_literal_exclusive_or_op) ##0 !bus_wr_go |=> ACC_OUT == ($past(ACC_OUT) ^ $past(INSTR_IN.literal))
            && $stable(CARRY_OUT) && !FILE_WRITE_OUT.we;
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong");

    // Zero judged from the visible result, so a broken result path cannot hide behind it
    property p_zero;
        INSTR_IN.valid && INSTR_IN.code != nibble_exchange_op && INSTR_IN.code <= acc_literal_exclusive_or_op
            |=> ZERO_OUT == ((FILE_WRITE_OUT.we ? FILE_WRITE_OUT.data : ACC_OUT) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    // Unknown codes must leave accumulator, zero, carry and file alone, without done
    property p_refused;
        INSTR_IN.valid && INSTR_IN.code > acc_literal_exclusive_or_op ##0 !bus_wr_go |=> !DONE_OUT
            && !FILE_WRITE_OUT.we && $stable(ACC_OUT) && $stable(ZERO_OUT) && $stable(CARRY_OUT);
    endproperty
    a_refused: assert property (p_refused) else $error("unknown code had an effect");

    property p_bus_answer;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |-> ##[1:2] !AVS_WAITREQUEST_OUT;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule : sxa_alu

// File: tb/sxa_regfile_model.sv
`timescale 1ns/100ps
// File registers beside the datapath: read is combinational, write-back on the strobe edge
module sxa_regfile_model (
    input wire logic CLOCK_IN,
    input wire logic [sxa_pkg::FADDR_W-1:0] ADDR_IN,
    input wire sxa_pkg::sxa_fwrite_type WR_IN,
    output logic [sxa_pkg::DATA_W-1:0] DATA_OUT
);
    import sxa_pkg::*;
    logic [DATA_W-1:0] mem_q [0:127];
    // Seeded so that neighbouring addresses never hold the same byte
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem_q[i] = 8'(i * 29 + 7);
        end
    end
    assign DATA_OUT = mem_q[ADDR_IN];
    // Only a real strobe writes; an unknown strobe leaves memory alone
    always @(posedge CLOCK_IN) begin
        if (WR_IN.we === 1'b1) begin
            mem_q[WR_IN.addr] <= WR_IN.data;
        end
    end
endmodule : sxa_regfile_model

// File: tb/subtract_xor_swap_alu_ops_tb.sv
`timescale 1ns/100ps
module subtract_xor_swap_alu_ops_tb;
    import sxa_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sxa_instr_type instr = '0;
    logic [7:0] fd, acc;
    sxa_fwrite_type fw;
    logic c, h, z, done, wreq;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'hF;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, got;
    logic [7:0] fv [0:127];
    logic [7:0] acc_e = 8'h00;
    logic [2:0] fl_e = 3'h0;
    logic [15:0] cnt_e = 16'h0000;
    int err_count = 0;
    int checks = 0;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    sxa_alu #(.COUNT_W(16)) dut_u (.CLOCK_IN(clk), .RESETN_IN(rst_n), .INSTR_IN(instr),
        .FILE_DATA_IN(fd), .FILE_WRITE_OUT(fw), .ACC_OUT(acc), .CARRY_OUT(c), .HALF_CARRY_OUT(h),
        .ZERO_OUT(z), .DONE_OUT(done), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq));
    sxa_regfile_model model_u (.CLOCK_IN(clk), .ADDR_IN(instr.faddr), .WR_IN(fw), .DATA_OUT(fd));

    task test_done;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk

    // Bus master: hold the request until the rising edge that sees waitrequest low
    task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        q = 32'h0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (n == 20) begin
            err_count++;
            test_done();
        end else begin
            // Data taken and request dropped at the accepting edge
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask : av

    // One instruction, expectations worked out from the operation table
    task op(input logic [2:0] cd, input logic [6:0] fa, input logic ds, input logic [7:0] k);
        logic [7:0] a, f, r;
        logic ok, fwe;
        a = acc_e; f = fv[fa]; ok = (cd < 3'h5); fwe = 1'b0; r = a;
        case (cd)
            3'h0: begin r = k - a; fl_e[0] = (a <= k); fl_e[1] = (a[3:0] <= k[3:0]); end
            3'h1: begin r = f - a; fl_e[0] = (a <= f); fl_e[1] = (a[3:0] <= f[3:0]); end
            3'h2: r = a ^ f;
            3'h3: r = {f[3:0], f[7:4]};
            3'h4: r = a ^ k;
            default: ;
        endcase
        if (ok && cd != 3'h3) fl_e[2] = (r == 8'h00);
        if (ok && ds && cd >= 3'h1 && cd <= 3'h3) begin
            fwe = 1'b1; fv[fa] = r;
        end else if (ok) acc_e = r;
        cnt_e++;
        @(posedge clk);
        instr <= '{1'b1, sxa_op_type'(cd), fa, ds, k};
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
        chk(acc, acc_e);
        chk({z, h, c}, fl_e);
        chk(done, ok);
        chk(fw.we, fwe);
        if (fwe) chk({fw.addr, fw.data}, {fa, r});
    endtask : op

    // Hang guard
    initial begin
        #2000000;
        err_count++;
        test_done();
    end

    initial begin
        for (int i = 0; i < 128; i++) fv[i] = 8'(i * 29 + 7);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({wreq, done, z, h, c, acc}, {5'h10, 8'h00});
        av(1'b1, ACC_OFS, 32'h3, got); acc_e = 8'h03;
        av(1'b0, ACC_OFS, 32'h0, got); chk(got, 32'h3);
        op(3'h0, 7'h00, 1'b0, 8'h05);
        op(3'h0, 7'h00, 1'b0, acc_e);
        op(3'h0, 7'h00, 1'b0, 8'h10);
        $display("test literal subtract done");
        // Every code, both destinations, spread of operands
        for (int i = 0; i < 32; i++) op(3'(i % 8), 7'(i * 5), i[3], 8'(i * 37));
        av(1'b1, ACC_OFS, {24'h0, fv[9]}, got); acc_e = fv[9];
        op(3'h1, 7'h09, 1'b1, 8'h00);
        op(3'h2, 7'h09, 1'b1, 8'h00);
        $display("test file ops done");
        av(1'b1, STATUS_OFS, 32'h7, got); fl_e = 3'h7;
        av(1'b0, STATUS_OFS, 32'h0, got); chk(got, 32'h7);
        op(3'h3, 7'h11, 1'b0, 8'h00);
        op(3'h4, 7'h00, 1'b0, 8'h5A);
        op(3'h2, 7'h12, 1'b0, 8'h00);
        $display("test flag keep done");
        // Unmapped place and a write with lane 0 disabled
        av(1'b1, 4'hC, 32'hFF, got);
        av(1'b0, 4'hC, 32'h0, got); chk(got, 32'h0);
        be <= 4'h0;
        av(1'b1, ACC_OFS, 32'hA5, got);
        be <= 4'hF;
        av(1'b0, ACC_OFS, 32'h0, got); chk(got, {24'h0, acc_e});
        av(1'b0, OPCNT_OFS, 32'h0, got); chk(got, {16'h0, cnt_e});
        $display("test bus done");
        // Reset in mid-run, then work again
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        acc_e = 8'h00; fl_e = 3'h0;
        #1;
        chk({z, h, c, acc}, 11'h0);
        op(3'h4, 7'h00, 1'b0, 8'h00);
        $display("test second reset done");
        test_done();
    end
endmodule : subtract_xor_swap_alu_ops_tb
